// ==== hw/esf_flags.sv ====
// Erase status flags with Wishbone slave and interrupt
`timescale 1ns/1ps
module esf_flags
  import esf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        hw_reset_n_i,
  input  wire logic        erase_done_i,
  input  wire logic        erase_fail_i,
  input  wire logic        erase_prot_i,
  input  wire logic        erase_suspend_i,
  input  wire logic        erase_resume_i,
  input  wire logic        standby_req_i,
  output logic             standby_o,
  output logic             erase_suspended_o,
  output logic             erase_error_o,
  output logic             irq_o
);
  logic       susp_q;
  logic       err_q;
  logic [2:0] irq_sts_q;
  logic [2:0] irq_mask_q;
  logic       ack_q;
  logic [31:0] dat_q;
  logic       pin_lvl;
  logic       hw_rst;
  logic       wr_en;
  logic       clr_sts;
  logic       sw_rst;
  logic       err_set;
  logic       err_clr;
  logic       flag_rst;
  logic [2:0] irq_ev;

  // ==========================================================
  // Reset pin comes from outside the clock domain
  esf_pin_sync u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (hw_reset_n_i),
    .level_o (pin_lvl)
  );
  assign hw_rst = ~pin_lvl;

  // ==========================================================
  // Address match, shared by read and write paths
  function automatic logic adr_is(input logic [7:0] a, input logic [7:0] r);
    adr_is = (a == r);
  endfunction

  // ==========================================================
  // Wishbone classic: ack one cycle after the request, one cycle wide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end
  assign wb_ack_o = ack_q;

  // Write lands on the edge where the master sees ack
  assign wr_en   = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
  assign clr_sts = wr_en & adr_is(wb_adr_i, ESF_ADR_CTRL) & wb_dat_i[ESF_BIT_CLR_STS];
  assign sw_rst  = wr_en & adr_is(wb_adr_i, ESF_ADR_CTRL) & wb_dat_i[ESF_BIT_SWRST];

  // Read data captured with the request; unmapped reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (wb_cyc_i & wb_stb_i & ~ack_q) begin
      dat_q <= 32'h0000_0000;
      if (adr_is(wb_adr_i, ESF_ADR_STATUS)) begin
        dat_q[ESF_BIT_SUSP] <= susp_q;
        dat_q[ESF_BIT_ERR]  <= err_q;
      end else if (adr_is(wb_adr_i, ESF_ADR_IRQ_STS)) begin
        dat_q[ESF_IRQ_W-1:0] <= irq_sts_q;
      end else if (adr_is(wb_adr_i, ESF_ADR_IRQ_MASK)) begin
        dat_q[ESF_IRQ_W-1:0] <= irq_mask_q;
      end
    end
  end
  assign wb_dat_o = dat_q;

  // ==========================================================
  // Erase-suspended flag
  assign flag_rst = hw_rst | sw_rst;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      susp_q <= ESF_RST_SUSP;
    end else if (flag_rst) begin
      susp_q <= 1'b0;
    end else if (erase_suspend_i) begin
      susp_q <= 1'b1;
    end else if (erase_resume_i) begin
      susp_q <= 1'b0;
    end
  end

  // ==========================================================
  // Erase-error flag; a new fault beats a same-cycle clear
  assign err_set = (erase_done_i & erase_fail_i) | erase_prot_i;
  assign err_clr = clr_sts | flag_rst;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= ESF_RST_ERR;
    end else if (err_set) begin
      err_q <= 1'b1;
    end else if (err_clr) begin
      err_q <= 1'b0;
    end
  end
  // No clear on a good erase: a later success must not hide the old fault

  // Standby gated by an outstanding error
  assign standby_o         = standby_req_i & ~err_q;
  assign erase_suspended_o = susp_q;
  assign erase_error_o     = err_q;

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  assign irq_ev = {erase_resume_i & susp_q, erase_suspend_i, err_set};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sts_q <= ESF_RST_IRQ;
    end else if (wr_en & adr_is(wb_adr_i, ESF_ADR_IRQ_STS)) begin
      irq_sts_q <= (irq_sts_q & ~wb_dat_i[ESF_IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_sts_q <= irq_sts_q | irq_ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= ESF_RST_IRQ;
    end else if (wr_en & adr_is(wb_adr_i, ESF_ADR_IRQ_MASK)) begin
      irq_mask_q <= wb_dat_i[ESF_IRQ_W-1:0];
    end
  end
  assign irq_o = |(irq_sts_q & irq_mask_q);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_susp_read;
    ack_q && !wb_we_i && adr_is(wb_adr_i, ESF_ADR_STATUS) |-> wb_dat_o[ESF_BIT_SUSP] == $past(susp_q);
  endproperty
  a_susp_read: assert property (p_susp_read) else $error("suspend bit misread");

  property p_susp_reset;
    $fell(rst_i) |-> !susp_q;
  endproperty
  a_susp_reset: assert property (@(posedge clk_i) p_susp_reset) else $error("suspend not reset");

  property p_err_set;
    err_set |=> err_q;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set");

  property p_err_prot;
    erase_prot_i ##1 1'b1 |-> err_q;
  endproperty
  a_err_prot: assert property (p_err_prot) else $error("protected erase not flagged");

  property p_err_hold;
    err_q && !err_clr |=> err_q;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");

  property p_err_clr;
    clr_sts && !err_set |=> !err_q;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("clear status ignored");

  property p_standby;
    err_q |-> !standby_o;
  endproperty
  a_standby: assert property (p_standby) else $error("standby with error");

  property p_standby_pass;
    !err_q && standby_req_i |-> standby_o;
  endproperty
  a_standby_pass: assert property (p_standby_pass) else $error("standby wrongly held");

  property p_irq_set;
    (|irq_ev) |=> (irq_sts_q & $past(irq_ev)) == $past(irq_ev);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt event lost");

  property p_err_read;
    ack_q && !wb_we_i && adr_is(wb_adr_i, ESF_ADR_STATUS) |-> wb_dat_o[ESF_BIT_ERR] == $past(err_q);
  endproperty
  a_err_read: assert property (p_err_read) else $error("error bit misread");

  property p_susp_clr;
    (erase_resume_i && !erase_suspend_i) || flag_rst |=> !susp_q;
  endproperty
  a_susp_clr: assert property (p_susp_clr) else $error("suspend not cleared");

  property p_ack;
    wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");

  c_err_then_clr: cover property (err_set ##[1:40] clr_sts);
  c_soft_reset: cover property (sw_rst && susp_q);
  c_standby: cover property ($fell(err_q) && standby_req_i);
  c_susp_resume: cover property (erase_suspend_i ##[1:20] erase_resume_i);
  c_irq: cover property ($rose(irq_o));
endmodule

// ==== hw/esf_pkg.sv ====
// Constants for the erase status flag bank
// Operation
// - Status bit 6 reads 1 while an erase is suspended and 0 otherwise.
// - The erase-suspended bit reads 0 after reset, meaning no suspended erase.
// - The erase-error flag is set to 1 when the last erase failed and is not cleared by a later good erase.
// - The erase-error flag is also set when an erase targets a protected sector.
// - The erase-error flag stays set until a clear-status transaction or a hard or soft reset.
// - The device does not enter standby while the erase-error flag is set.
// - The erase-error flag sits in bit 5 of the volatile status register and is host readable.
package esf_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ESF_ADR_STATUS   = 8'h00;
  localparam logic [7:0] ESF_ADR_CTRL     = 8'h04;
  localparam logic [7:0] ESF_ADR_IRQ_STS  = 8'h08;
  localparam logic [7:0] ESF_ADR_IRQ_MASK = 8'h0C;
  // ==========================================================
  // Field positions
  localparam int ESF_BIT_SUSP      = 6;
  localparam int ESF_BIT_ERR       = 5;
  localparam int ESF_BIT_CLR_STS   = 0;
  localparam int ESF_BIT_SWRST     = 1;
  localparam int ESF_IRQ_ERR       = 0;
  localparam int ESF_IRQ_SUSP      = 1;
  localparam int ESF_IRQ_RESUME    = 2;
  localparam int ESF_IRQ_W         = 3;
  // ==========================================================
  // Reset values
  localparam logic       ESF_RST_SUSP  = 1'b0;
  localparam logic       ESF_RST_ERR   = 1'b0;
  localparam logic [2:0] ESF_RST_IRQ   = 3'h0;
  localparam logic       ESF_RST_PIN   = 1'b1;
  localparam logic [2:0] ESF_RST_SYNC  = 3'h7;
endpackage

// ==== hw/esf_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module esf_pin_sync
  import esf_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] sync_q;

  // ==========================================================
  // Sync chain; only stages two and three feed the filter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_q <= ESF_RST_SYNC;
    end else begin
      sync_q <= {sync_q[1:0], pin_i};
    end
  end

  // Level changes only once the two late stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= ESF_RST_PIN;
    end else if (sync_q[1] == sync_q[2]) begin
      level_o <= sync_q[2];
    end
  end
endmodule

// ==== bench/esf_host.sv ====
// Wishbone host model driving the erase status flag registers
`timescale 1ns/1ps
module esf_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h00000000;
  end
  // ==========================================================
  // One classic cycle; caller enters just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    cyc_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    // No own limit: only the bench timeout may end a hung wait
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    we_o  <= 1'b0;
    // Released data inverted so a stale value never looks valid
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule

// ==== bench/esf_flags_test.sv ====
// Self-checking bench for the erase status flag bank
`timescale 1ns/1ps
module esf_flags_test;
  import esf_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, we, ack, hw_n, sreq, stby, susp, err, irq;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [4:0]  ev;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc_n = 0;
  initial begin
    ev = 5'h00;
    hw_n = 1'b1;
    sreq = 1'b0;
  end
  always #5 clk_i = ~clk_i;
  esf_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
                 .adr_o(adr), .dat_o(wdat));
  esf_flags DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .hw_reset_n_i(hw_n), .erase_done_i(ev[0]), .erase_fail_i(ev[1]), .erase_prot_i(ev[2]),
    .erase_suspend_i(ev[3]), .erase_resume_i(ev[4]), .standby_req_i(sreq),
    .standby_o(stby), .erase_suspended_o(susp), .erase_error_o(err), .irq_o(irq));
  // ==========================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Bus and event helpers
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h00000000, q);
    chk(nm, q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  // One-cycle event pulse, then room for the flags to land
  task automatic fire(input logic [4:0] v);
    ev <= v;
    @(posedge clk_i);
    ev <= 5'h00;
    repeat (2) @(posedge clk_i);
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ESF_ADR_STATUS, 32'h00000000, "status after reset");
    chk("irq after reset", {31'h0, irq}, 32'h00000000);
    $display("test 1 done");
    fire(5'h08);
    rd(ESF_ADR_STATUS, 32'h00000040, "suspended bit");
    chk("suspend pin", {31'h0, susp}, 32'h00000001);
    fire(5'h10);
    rd(ESF_ADR_STATUS, 32'h00000000, "suspend after resume");
    rd(ESF_ADR_IRQ_STS, 32'h00000006, "irq status events");
    $display("test 2 done");
    wr(ESF_ADR_IRQ_MASK, 32'h00000001);
    rd(ESF_ADR_IRQ_MASK, 32'h00000001, "irq mask readback");
    sreq <= 1'b1;
    fire(5'h04);
    rd(ESF_ADR_STATUS, 32'h00000020, "error on protected");
    chk("error pin", {31'h0, err}, 32'h00000001);
    chk("standby held off", {31'h0, stby}, 32'h00000000);
    chk("irq on error", {31'h0, irq}, 32'h00000001);
    repeat (10) @(posedge clk_i);
    rd(ESF_ADR_STATUS, 32'h00000020, "error sticky");
    wr(ESF_ADR_CTRL, 32'h00000001);
    rd(ESF_ADR_STATUS, 32'h00000000, "error after clear");
    chk("standby after clear", {31'h0, stby}, 32'h00000001);
    chk("error pin after clear", {31'h0, err}, 32'h00000000);
    wr(ESF_ADR_IRQ_STS, 32'h00000001);
    chk("irq after w1c", {31'h0, irq}, 32'h00000000);
    rd(ESF_ADR_IRQ_STS, 32'h00000006, "irq status after w1c");
    $display("test 3 done");
    fire(5'h03);
    rd(ESF_ADR_STATUS, 32'h00000020, "error on failed erase");
    fire(5'h01);
    rd(ESF_ADR_STATUS, 32'h00000020, "error kept over good erase");
    wr(ESF_ADR_CTRL, 32'h00000001);
    fire(5'h01);
    rd(ESF_ADR_STATUS, 32'h00000000, "error after good erase");
    $display("test 4 done");
    fire(5'h04);
    fire(5'h08);
    rd(ESF_ADR_STATUS, 32'h00000060, "both flags set");
    wr(ESF_ADR_CTRL, 32'h00000002);
    rd(ESF_ADR_STATUS, 32'h00000000, "flags after soft reset");
    chk("suspend pin after soft reset", {31'h0, susp}, 32'h00000000);
    fire(5'h04);
    hw_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    hw_n <= 1'b1;
    repeat (5) @(posedge clk_i);
    rd(ESF_ADR_STATUS, 32'h00000000, "error after pin reset");
    $display("test 5 done");
    wr(ESF_ADR_STATUS, 32'h000000FF);
    rd(ESF_ADR_STATUS, 32'h00000000, "status read only");
    rd(8'h10, 32'h00000000, "unmapped read");
    $display("test 6 done");
    tally_and_finish();
  end
endmodule
